//--- src/framer_consts.svh
// constants of the serial telegram framer
// Behaviour
// - one master, up to 126 followers; master picks a follower by address byte.
// - follower transmits only in answer to a master request, never unprompted.
// - half duplex: a node never transmits and receives on the line together.
// - short 8-byte process, long 16-byte parameter, and variable text telegrams.
// - node address 1 to 126, baud 2400 to 115200, even parity, one stop.
// - character is start, eight data, parity, stop: eleven bit times.
// - data bits plus parity bit hold an even count of ones; receiver checks.
// - telegram is start char 0x02, length, address, data bytes, check byte.
// - length byte is data bytes plus two: six for four, fourteen for twelve.
// - text telegrams carry length ten plus the number of text characters.
// - address bit 7 set selects format; bits 6..0 address, zero is broadcast.
// - reply carries the received address byte unchanged.
// - check byte is running XOR of telegram bytes, cleared before first byte.
// - process block: control word, reference in; status word, frequency out.
// - parameter block is twelve bytes and also holds the process block.
// - text block variant of the data field is accepted on receive and answered with a long telegram.
// - id word bits 15..12 carry command in, response code out.
// - commands none, read, write word, write dword, nv dword, nv word, text.
// - responses none, word sent, dword sent, cannot perform, text sent.
// - failed command answers code 0111 plus a fault report code.
// - fault 0 is illegal parameter number, fault 1 is parameter locked.
// - received control word drives start, stops, reset, speeds, relays etc.
// - id word bits 11..0 carry the parameter number.
`ifndef FRAMER_CONSTS_SVH
`define FRAMER_CONSTS_SVH
`define START_CHAR   8'h02
`define LEN_SHORT    8'h06
`define LEN_LONG     8'h0e
`define LEN_TEXT_FIX 8'h0a
`define LEN_OVERHEAD 8'h02
`define ADR_FMT_BIT  7
`define ADR_BCAST    7'h00
`define ADR_MAX      7'h7e
`define CHAR_LAST    4'ha
`define DIV_W        17
`define DATA_BUF     32
`define OFS_PROC     8'h08
`define CMD_NONE     4'h0
`define CMD_READ     4'h1
`define CMD_WR_W     4'h2
`define CMD_WR_D     4'h3
`define CMD_WR_DE    4'hd
`define CMD_WR_WE    4'he
`define CMD_RD_TXT   4'hf
`define RSP_NONE     4'h0
`define RSP_WORD     4'h1
`define RSP_DWORD    4'h2
`define RSP_FAIL     4'h7
`define RSP_TEXT     4'hf
`define FLT_BAD_NUM  8'h00
`define FLT_LOCKED   8'h01
`define FLT_NOT_SUPP 8'hfd
`endif

//--- src/framer_pkg.sv
// types of the serial telegram framer
`include "framer_consts.svh"
package framer_pkg;
	typedef enum logic [3:0] {
		S_HUNT  = 4'h0,
		S_LEN   = 4'h1,
		S_ADR   = 4'h2,
		S_DATA  = 4'h3,
		S_CHECK = 4'h4,
		S_EXEC  = 4'h5,
		S_PARAM = 4'h6,
		S_SEND  = 4'h7,
		S_DRAIN = 4'h8
	} tel_state_t;
	typedef struct packed {
		logic       valid;
		logic       perr;
		logic [7:0] data;
	} rx_char_t;
	typedef struct packed {
		logic        valid;
		logic [3:0]  cmd;
		logic [11:0] pnum;
		logic [15:0] ind;
		logic [31:0] value;
	} param_req_t;
	typedef struct packed {
		logic        valid;
		logic        num_bad;
		logic        locked;
		logic        dword;
		logic [31:0] rdata;
	} param_ans_t;
	typedef struct packed {
		logic [1:0]        sync;
		logic              rx_busy;
		logic [`DIV_W-1:0] rx_cnt;
		logic [3:0]        rx_bit;
		logic [10:0]       rx_sh;
		rx_char_t          rxc;
		logic              tx_busy;
		logic [`DIV_W-1:0] tx_cnt;
		logic [3:0]        tx_bit;
		logic [10:0]       tx_sh;
	} line_state_t;
	typedef struct packed {
		tel_state_t                  st;
		logic [7:0]                  len;
		logic [7:0]                  cnt;
		logic [7:0]                  xsum;
		logic [7:0]                  adr;
		logic                        perr;
		logic [`DATA_BUF-1:0][7:0]   buff;
		logic [15:0]                 ctrl_word;
		logic [15:0]                 ref_value;
		logic                        ctrl_strobe;
		param_req_t                  req;
		logic [3:0]                  rsp;
		logic [31:0]                 rval;
		logic                        tx_go;
		logic [7:0]                  tx_byte;
		logic [7:0]                  tx_idx;
		logic [7:0]                  tx_last;
		logic                        tx_long;
	} framer_state_t;
endpackage

//--- src/uart_char_line.sv
// eleven-bit even-parity character receiver and transmitter for the line
`timescale 1ns/1ns
`include "framer_consts.svh"
module uart_char_line (
	// clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 rst,
	// bit time in clk_sys cycles
	input  wire logic [`DIV_W-1:0]    bit_div,
	// line pins
	input  wire logic                 line_rx,
	output logic                      line_tx,
	output logic                      line_oe,
	// character side
	input  wire logic                 tx_start,
	input  wire logic [7:0]           tx_byte,
	output logic                      tx_busy,
	output framer_pkg::rx_char_t      rx_char
);
	framer_pkg::line_state_t s;
	framer_pkg::line_state_t n;
	logic [10:0] shin;

	always_comb begin
		n = s;
		n.rxc.valid = 1'b0;
		n.sync = {s.sync[0], line_rx};
		shin = {s.sync[1], s.rx_sh[10:1]};
		if (!s.rx_busy) begin
			if (!s.sync[1] && !s.tx_busy && !tx_start) begin
				n.rx_busy = 1'b1;
				n.rx_cnt = bit_div >> 1;
				n.rx_bit = 4'h0;
			end
		end else if (s.rx_cnt == '0) begin
			n.rx_cnt = bit_div - 1'b1;
			n.rx_sh = shin;
			n.rx_bit = s.rx_bit + 4'h1;
			// glitch shorter than half a bit is no start
			if (s.rx_bit == 4'h0 && s.sync[1])
				n.rx_busy = 1'b0;
			if (s.rx_bit == `CHAR_LAST) begin
				n.rx_busy = 1'b0;
				n.rxc.valid = 1'b1;
				n.rxc.data = shin[8:1];
				n.rxc.perr = (^shin[9:1]) | ~shin[10];
			end
		end else begin
			n.rx_cnt = s.rx_cnt - 1'b1;
		end
		if (tx_start && !s.tx_busy) begin
			n.tx_busy = 1'b1;
			n.tx_sh = {1'b1, ^tx_byte, tx_byte, 1'b0};
			n.tx_cnt = bit_div - 1'b1;
			n.tx_bit = 4'h0;
		end else if (s.tx_busy) begin
			if (s.tx_cnt == '0) begin
				n.tx_cnt = bit_div - 1'b1;
				n.tx_bit = s.tx_bit + 4'h1;
				n.tx_sh = {1'b1, s.tx_sh[10:1]};
				if (s.tx_bit == `CHAR_LAST)
					n.tx_busy = 1'b0;
			end else begin
				n.tx_cnt = s.tx_cnt - 1'b1;
			end
		end
		// own echo must not be taken as a character
		if (n.tx_busy)
			n.rx_busy = 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.sync <= 2'h3;
			s.tx_sh <= 11'h7ff;
		end else begin
			s <= n;
		end
	end

	assign line_tx = s.tx_sh[0];
	assign line_oe = s.tx_busy;
	assign tx_busy = s.tx_busy;
	assign rx_char = s.rxc;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_tx_even_parity: assert property (tx_start && !s.tx_busy |=> ^s.tx_sh[9:1] == 1'b0)
		else $error("transmitted parity is not even");
	a_no_rx_in_tx: assert property (s.tx_busy |-> !s.rx_busy && !s.rxc.valid)
		else $error("receiver active while transmitting");
	a_char_eleven: assert property (s.tx_busy && s.tx_cnt == '0 && s.tx_bit == `CHAR_LAST
		|=> !s.tx_busy && line_tx)
		else $error("character did not end after eleven bits");
endmodule

//--- src/drive_serial_telegram_framer.sv
// follower telegram framer: receive, check, apply and answer master telegrams
`timescale 1ns/1ns
`include "framer_consts.svh"
module drive_serial_telegram_framer #(
	parameter int DATA_MAX = `DATA_BUF
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	// configuration
	input  wire logic [6:0]            own_addr,
	input  wire logic [`DIV_W-1:0]     baud_div,
	// rs485 transceiver
	input  wire logic                  line_rx,
	output logic                       line_tx,
	output logic                       line_oe,
	// process data
	output logic [15:0]                ctrl_word,
	output logic [15:0]                ref_value,
	output logic                       ctrl_strobe,
	input  wire logic [15:0]           status_word,
	input  wire logic [15:0]           out_freq,
	// parameter access
	output framer_pkg::param_req_t     param_req,
	input  wire framer_pkg::param_ans_t param_ans
);
	if (DATA_MAX < 12 || DATA_MAX > `DATA_BUF) begin : g_chk
		$error("DATA_MAX must lie between 12 and the data buffer depth");
	end

	framer_pkg::framer_state_t s;
	framer_pkg::framer_state_t n;
	framer_pkg::rx_char_t      rxc;
	logic                      tx_busy;
	logic [7:0]                proc_ofs;
	logic [3:0]                cmd;

	uart_char_line u_line (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.bit_div  (baud_div),
		.line_rx  (line_rx),
		.line_tx  (line_tx),
		.line_oe  (line_oe),
		.tx_start (s.tx_go),
		.tx_byte  (s.tx_byte),
		.tx_busy  (tx_busy),
		.rx_char  (rxc)
	);

	// short, long and text lengths; DATA_MAX bounds the text length
	function automatic logic len_ok(input logic [7:0] l);
		len_ok = l == `LEN_SHORT || l == `LEN_LONG;
		if (l >= `LEN_TEXT_FIX && {24'h0, l - `LEN_OVERHEAD} <= DATA_MAX)
			len_ok = 1'b1;
	endfunction

	function automatic logic is_bcast(input logic [7:0] a);
		is_bcast = a[6:0] == `ADR_BCAST;
	endfunction

	// own address outside 1..126 accepts nothing but broadcast
	function automatic logic adr_hit(input logic [7:0] a, input logic [6:0] own);
		adr_hit = a[`ADR_FMT_BIT] && (is_bcast(a) ||
			(a[6:0] == own && own != `ADR_BCAST && own <= `ADR_MAX));
	endfunction

	function automatic logic is_write(input logic [3:0] c);
		is_write = c == `CMD_WR_W || c == `CMD_WR_D ||
			c == `CMD_WR_DE || c == `CMD_WR_WE;
	endfunction

	function automatic logic is_dwrite(input logic [3:0] c);
		is_dwrite = c == `CMD_WR_D || c == `CMD_WR_DE;
	endfunction

	function automatic logic cmd_known(input logic [3:0] c);
		cmd_known = is_write(c) || c == `CMD_READ || c == `CMD_RD_TXT;
	endfunction

	// payload byte k of the reply; the short reply is the process block only
	function automatic logic [7:0] reply_data(
		input framer_pkg::framer_state_t q,
		input logic [7:0]                k,
		input logic [15:0]               sw,
		input logic [15:0]               fr
	);
		logic [95:0] v;
		logic [6:0]  base;
		if (q.tx_long)
			v = {q.rsp, q.req.pnum, q.req.ind, q.rval, sw, fr};
		else
			v = {sw, fr, 64'h0};
		base = 7'h5f - {k[3:0], 3'h0};
		reply_data = v[base -: 8];
	endfunction

	function automatic logic [7:0] reply_byte(
		input framer_pkg::framer_state_t q,
		input logic [15:0]               sw,
		input logic [15:0]               fr
	);
		case (q.tx_idx)
			8'h00: reply_byte = `START_CHAR;
			8'h01: reply_byte = q.tx_long ? `LEN_LONG : `LEN_SHORT;
			8'h02: reply_byte = q.adr;
			default: reply_byte = reply_data(q, q.tx_idx - 8'h03, sw, fr);
		endcase
	endfunction

	assign proc_ofs = (s.len == `LEN_SHORT) ? 8'h00 : `OFS_PROC;
	assign cmd = s.buff[0][7:4];

	always_comb begin
		n = s;
		n.ctrl_strobe = 1'b0;
		n.req.valid = 1'b0;
		n.tx_go = 1'b0;
		if (rxc.valid && s.st != framer_pkg::S_HUNT)
			n.perr = s.perr | rxc.perr;
		case (s.st)
			framer_pkg::S_HUNT: begin
				if (rxc.valid && !rxc.perr && rxc.data == `START_CHAR) begin
					n.xsum = 8'h00 ^ rxc.data;
					n.perr = 1'b0;
					n.st = framer_pkg::S_LEN;
				end
			end
			framer_pkg::S_LEN: begin
				if (rxc.valid) begin
					n.len = rxc.data;
					n.xsum = s.xsum ^ rxc.data;
					if (len_ok(rxc.data))
						n.st = framer_pkg::S_ADR;
					else
						n.st = framer_pkg::S_HUNT;
				end
			end
			framer_pkg::S_ADR: begin
				if (rxc.valid) begin
					n.adr = rxc.data;
					n.xsum = s.xsum ^ rxc.data;
					n.cnt = 8'h00;
					n.st = framer_pkg::S_DATA;
				end
			end
			framer_pkg::S_DATA: begin
				if (rxc.valid) begin
					n.buff[s.cnt[4:0]] = rxc.data;
					n.xsum = s.xsum ^ rxc.data;
					n.cnt = s.cnt + 8'h01;
					if (n.cnt == s.len - `LEN_OVERHEAD)
						n.st = framer_pkg::S_CHECK;
				end
			end
			framer_pkg::S_CHECK: begin
				if (rxc.valid) begin
					// a damaged or foreign telegram leaves no trace
					if (!n.perr && s.xsum == rxc.data && adr_hit(s.adr, own_addr))
						n.st = framer_pkg::S_EXEC;
					else
						n.st = framer_pkg::S_HUNT;
				end
			end
			framer_pkg::S_EXEC: begin
				n.ctrl_word = {s.buff[proc_ofs[4:0]], s.buff[proc_ofs[4:0] + 5'h01]};
				n.ref_value = {s.buff[proc_ofs[4:0] + 5'h02],
					s.buff[proc_ofs[4:0] + 5'h03]};
				n.ctrl_strobe = 1'b1;
				n.tx_long = s.len != `LEN_SHORT;
				n.tx_last = (s.len != `LEN_SHORT ? `LEN_LONG : `LEN_SHORT) + 8'h01;
				n.tx_idx = 8'h00;
				n.xsum = 8'h00;
				n.rsp = `RSP_NONE;
				n.rval = 32'h0;
				n.req.cmd = cmd;
				n.req.pnum = {s.buff[0][3:0], s.buff[1]};
				n.req.ind = {s.buff[2], s.buff[3]};
				n.req.value = {s.buff[4], s.buff[5], s.buff[6], s.buff[7]};
				if (is_bcast(s.adr))
					n.st = framer_pkg::S_HUNT;
				else
					n.st = framer_pkg::S_SEND;
				if (s.len != `LEN_SHORT && cmd != `CMD_NONE) begin
					if (cmd_known(cmd)) begin
						n.req.valid = 1'b1;
						n.st = framer_pkg::S_PARAM;
					end else begin
						n.rsp = `RSP_FAIL;
						n.rval = {24'h0, `FLT_NOT_SUPP};
					end
				end
			end
			framer_pkg::S_PARAM: begin
				// the parameter store may take any time to answer
				if (param_ans.valid) begin
					if (param_ans.num_bad) begin
						n.rsp = `RSP_FAIL;
						n.rval = {24'h0, `FLT_BAD_NUM};
					end else if (is_write(s.req.cmd) && param_ans.locked) begin
						n.rsp = `RSP_FAIL;
						n.rval = {24'h0, `FLT_LOCKED};
					end else if (s.req.cmd == `CMD_RD_TXT) begin
						n.rsp = `RSP_TEXT;
						n.rval = param_ans.rdata;
					end else if (is_write(s.req.cmd)) begin
						n.rsp = is_dwrite(s.req.cmd) ? `RSP_DWORD : `RSP_WORD;
						n.rval = is_dwrite(s.req.cmd) ? s.req.value
							: {16'h0, s.req.value[15:0]};
					end else begin
						n.rsp = param_ans.dword ? `RSP_DWORD : `RSP_WORD;
						n.rval = param_ans.dword ? param_ans.rdata
							: {16'h0, param_ans.rdata[15:0]};
					end
					if (is_bcast(s.adr))
						n.st = framer_pkg::S_HUNT;
					else
						n.st = framer_pkg::S_SEND;
				end
			end
			framer_pkg::S_SEND: begin
				if (!tx_busy && !s.tx_go) begin
					if (s.tx_idx == s.tx_last) begin
						n.tx_byte = s.xsum;
						n.st = framer_pkg::S_DRAIN;
					end else begin
						n.tx_byte = reply_byte(s, status_word, out_freq);
						n.xsum = s.xsum ^ n.tx_byte;
					end
					n.tx_go = 1'b1;
					n.tx_idx = s.tx_idx + 8'h01;
				end
			end
			framer_pkg::S_DRAIN: begin
				// line released only after the check byte has left
				if (!tx_busy && !s.tx_go)
					n.st = framer_pkg::S_HUNT;
			end
			default: begin
				n.st = framer_pkg::S_HUNT;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s <= '0;
			s.st <= framer_pkg::S_HUNT;
		end else begin
			s <= n;
		end
	end

	assign ctrl_word = s.ctrl_word;
	assign ref_value = s.ref_value;
	assign ctrl_strobe = s.ctrl_strobe;
	assign param_req = s.req;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence s_start_seen;
		s.st == framer_pkg::S_HUNT && rxc.valid && !rxc.perr && rxc.data == `START_CHAR;
	endsequence
	sequence s_param_bad;
		s.st == framer_pkg::S_PARAM && param_ans.valid && param_ans.num_bad;
	endsequence
	sequence s_bad_check;
		s.st == framer_pkg::S_CHECK && rxc.valid && s.xsum != rxc.data;
	endsequence

	a_start_opens: assert property (s_start_seen |=> s.st == framer_pkg::S_LEN
		&& s.xsum == `START_CHAR)
		else $error("start char did not open a telegram with cleared checksum");
	a_fault_num: assert property (s_param_bad |=> s.rsp == `RSP_FAIL
		&& s.rval[7:0] == `FLT_BAD_NUM ##1 s.st == framer_pkg::S_SEND
		|| s.st == framer_pkg::S_HUNT)
		else $error("bad parameter number not reported");
	a_bad_dropped: assert property (s_bad_check |=> s.st == framer_pkg::S_HUNT
		##1 !line_oe)
		else $error("telegram with bad check byte was not dropped");
	a_bcast_quiet: assert property (s.st == framer_pkg::S_SEND |->
		s.adr[`ADR_FMT_BIT] && s.adr[6:0] != `ADR_BCAST)
		else $error("reply under way to broadcast or bad address");
	a_tx_on_request: assert property (line_oe |->
		s.st == framer_pkg::S_SEND || s.st == framer_pkg::S_DRAIN)
		else $error("line driven outside a reply");
	a_adr_echo: assert property (s.tx_go && s.tx_idx == 8'h03 |->
		s.tx_byte == s.adr)
		else $error("reply address differs from request");
	a_reply_len: assert property (s.tx_go && s.tx_idx == 8'h02 |->
		s.tx_byte == (s.tx_long ? `LEN_LONG : `LEN_SHORT))
		else $error("reply length byte wrong");
	a_ctrl_apply: assert property (s.st == framer_pkg::S_EXEC |=> ctrl_strobe
		##1 !ctrl_strobe)
		else $error("control word strobe not a single pulse");
endmodule

//--- verif/bus_master_model.sv
// behavioural bus master: sends request telegrams, collects reply characters
`timescale 1ns/1ns
`include "framer_consts.svh"
module bus_master_model (
	// clock
	input  wire logic              clk_sys,
	// bit time
	input  wire logic [`DIV_W-1:0] baud_div,
	// line
	output logic                   line_rx,
	input  wire logic              line_tx,
	input  wire logic              line_oe
);
	logic [7:0]  rx_q[$];
	int          rx_bad;
	int          oe_clash;
	logic        sending;
	logic [10:0] sh;
	logic        oe_ok;
	// released line is held high by the bias network
	wire logic   wire_lvl = line_oe ? line_tx : 1'b1;

	initial begin
		line_rx = 1'b1;
		sending = 1'b0;
		rx_bad = 0;
		oe_clash = 0;
	end

	// start, data lsb first, even parity, stop; bad_par breaks parity on purpose
	task automatic send_byte(input logic [7:0] b, input logic bad_par);
		logic [10:0] f;
		f = {1'b1, ^b ^ bad_par, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line_rx <= f[i];
			repeat (baud_div) @(posedge clk_sys);
		end
	endtask

	// bad: 0 clean, 1 wrong check byte, 2 parity error on address byte
	task automatic send_frame(input logic [7:0] adr, input logic [7:0] d[$], input int bad);
		logic [7:0] t[$];
		logic [7:0] x;
		t = '{8'h02, 8'(d.size() + 2), adr};
		t = {t, d};
		x = 8'h00;
		foreach (t[i]) x ^= t[i];
		t.push_back(x ^ {7'h00, bad == 1});
		sending = 1'b1;
		foreach (t[i]) begin
			// the reply may start inside our last stop bit
			if (i == t.size() - 1) sending = 1'b0;
			send_byte(t[i], bad == 2 && i == 2);
		end
	endtask

	always @(posedge clk_sys) begin
		if (sending && line_oe) oe_clash <= oe_clash + 1;
	end

	always begin
		@(posedge clk_sys);
		if (line_oe && !line_tx) begin
			oe_ok = 1'b1;
			repeat (baud_div / 2) @(posedge clk_sys);
			for (int i = 0; i < 11; i++) begin
				sh[i] = wire_lvl;
				oe_ok = oe_ok & line_oe;
				if (i < 10) repeat (baud_div) @(posedge clk_sys);
			end
			if (sh[0] || !sh[10] || ^sh[9:1] || !oe_ok) rx_bad++;
			rx_q.push_back(sh[8:1]);
		end
	end
endmodule

//--- verif/test_drive_serial_telegram_framer.sv
// self-checking bench of the telegram framer against a behavioural master
`timescale 1ns/1ns
`include "framer_consts.svh"
module test_drive_serial_telegram_framer;
	localparam logic [`DIV_W-1:0] BD = 12;
	localparam logic [15:0]       ST = 16'hc3a5;
	localparam logic [15:0]       FQ = 16'h1f40;
	logic                   clk_sys;
	logic                   rst;
	logic [6:0]             own_addr;
	logic [`DIV_W-1:0]      baud_div;
	logic                   line_rx;
	logic                   line_tx;
	logic                   line_oe;
	logic [15:0]            ctrl_word;
	logic [15:0]            ref_value;
	logic                   ctrl_strobe;
	logic [15:0]            status_word;
	logic [15:0]            out_freq;
	framer_pkg::param_req_t param_req;
	framer_pkg::param_ans_t param_ans;
	framer_pkg::param_ans_t ans_cfg;
	framer_pkg::param_req_t req_seen;
	int                     ans_dly;
	int                     ans_wait = 0;
	int                     req_cnt = 0;
	int                     strobe_cnt = 0;
	int                     error_cnt = 0;
	int                     samples_checked = 0;

	drive_serial_telegram_framer u_drive_serial_telegram_framer (
		.clk_sys(clk_sys), .rst(rst), .own_addr(own_addr), .baud_div(baud_div),
		.line_rx(line_rx), .line_tx(line_tx), .line_oe(line_oe),
		.ctrl_word(ctrl_word), .ref_value(ref_value), .ctrl_strobe(ctrl_strobe),
		.status_word(status_word), .out_freq(out_freq),
		.param_req(param_req), .param_ans(param_ans)
	);
	bus_master_model u_bus_master_model (
		.clk_sys(clk_sys), .baud_div(baud_div), .line_rx(line_rx),
		.line_tx(line_tx), .line_oe(line_oe)
	);

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (ctrl_strobe === 1'b1) strobe_cnt <= strobe_cnt + 1;
	// parameter store answers after ans_dly cycles, prompt or slow
	always @(posedge clk_sys) begin
		param_ans <= (ans_wait == 1 && param_req.valid !== 1'b1) ? ans_cfg : '0;
		if (param_req.valid === 1'b1) begin
			req_cnt <= req_cnt + 1;
			req_seen <= param_req;
			ans_wait <= ans_dly;
		end else if (ans_wait > 0) ans_wait <= ans_wait - 1;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// check byte appended here, then the whole reply compared
	task automatic expect_reply(input logic [7:0] e[$]);
		logic [7:0] x;
		int         n;
		x = 8'h00;
		foreach (e[i]) x ^= e[i];
		e.push_back(x);
		n = 0;
		while (u_bus_master_model.rx_q.size() < e.size() && n < 20000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 20000) begin
			error_cnt++;
			tally_and_finish;
		end else begin
			foreach (e[i]) check("reply byte", e[i], u_bus_master_model.rx_q[i]);
			u_bus_master_model.rx_q.delete();
			repeat (BD) @(posedge clk_sys);
		end
	endtask

	task automatic expect_silence(input logic [15:0] cw, input int s0);
		repeat (BD * 40) @(posedge clk_sys);
		check("reply chars", 0, u_bus_master_model.rx_q.size());
		check("ctrl word", {16'h0, cw}, {16'h0, ctrl_word});
		check("strobe count", s0, strobe_cnt);
	endtask

	task automatic s_reset;
		check("idle line", 2'b10, {line_tx, line_oe});
		check("ctrl after reset", 0, {ctrl_word, ref_value});
		check("req after reset", 0, {31'h0, param_req.valid});
	endtask

	task automatic s_short;
		int s0;
		s0 = strobe_cnt;
		u_bus_master_model.send_frame(8'hfe, '{8'h12, 8'h34, 8'hab, 8'hcd}, 0);
		expect_reply('{8'h02, 8'h06, 8'hfe, ST[15:8], ST[7:0], FQ[15:8], FQ[7:0]});
		check("ctrl and ref", 32'h1234abcd, {ctrl_word, ref_value});
		check("strobe count", s0 + 1, strobe_cnt);
	endtask

	task automatic s_bcast;
		int s0;
		s0 = strobe_cnt;
		u_bus_master_model.send_frame(8'h80, '{8'h01, 8'h02, 8'h03, 8'h04}, 0);
		expect_silence(16'h0102, s0 + 1);
	endtask

	// foreign address, bad check byte, bad parity, format bit clear
	task automatic s_drop;
		int s0;
		s0 = strobe_cnt;
		for (int m = 0; m < 4; m++) begin
			u_bus_master_model.send_frame(m == 0 ? 8'h85 : m == 3 ? 8'h7e : 8'hfe,
				'{8'hee, 8'hee, 8'hee, 8'hee}, m == 1 ? 1 : m == 2 ? 2 : 0);
			expect_silence(16'h0102, s0);
		end
	endtask

	function automatic logic [35:0] expect_ans(logic [3:0] c, logic bad, logic lock,
			logic dw, logic [31:0] v, logic [31:0] rd);
		if (c == 4'h0) return {4'h0, 32'h0};
		if (!(c inside {4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf})) return {4'h7, 32'hfd};
		if (bad) return {4'h7, 32'h0};
		if (lock && c != 4'h1 && c != 4'hf) return {4'h7, 32'h1};
		if (c == 4'hf) return {4'hf, rd};
		if (c == 4'h1) return dw ? {4'h2, rd} : {4'h1, 16'h0, rd[15:0]};
		return (c == 4'h3 || c == 4'hd) ? {4'h2, v} : {4'h1, 16'h0, v[15:0]};
	endfunction

	task automatic s_param;
		logic [3:0]  cmds [11];
		logic [3:0]  c;
		logic [31:0] v;
		logic [31:0] rd;
		logic [35:0] ex;
		logic [7:0]  d[$];
		int          r0;
		cmds = '{4'h1, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf, 4'h0, 4'h5, 4'h1, 4'he};
		for (int i = 0; i < 11; i++) begin
			c = cmds[i];
			v = (c == 4'h3 || c == 4'hd) ? 32'h5678_9abc : 32'h0000_03e8;
			rd = (i == 1 || c == 4'hf) ? 32'h0102_0304 : 32'h0000_0506;
			ans_cfg <= {1'b1, i == 9, i == 10, i == 1, rd};
			ans_dly <= (i % 2 == 1) ? 30 : 1;
			ex = expect_ans(c, i == 9, i == 10, i == 1, v, rd);
			d = '{{c, 4'h1}, 8'h9e, 8'h04, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0],
				8'h47, 8'(i), 8'h20, 8'h00};
			if (c == 4'hf) d = {d, 8'h61, 8'h62};
			r0 = req_cnt;
			u_bus_master_model.send_frame(8'hfe, d, 0);
			expect_reply('{8'h02, 8'h0e, 8'hfe, {ex[35:32], 4'h1}, 8'h9e, 8'h04, 8'h00,
				ex[31:24], ex[23:16], ex[15:8], ex[7:0],
				ST[15:8], ST[7:0], FQ[15:8], FQ[7:0]});
			check("request count", (c == 4'h0 || c == 4'h5) ? 0 : 1, req_cnt - r0);
			if (c != 4'h0 && c != 4'h5) begin
				check("request fields", {c, 12'h19e, v[15:0]},
					{req_seen.cmd, req_seen.pnum, req_seen.value[15:0]});
				check("request value", v, req_seen.value);
				check("request index", 32'h0400, {16'h0, req_seen.ind});
			end
			check("process control", {24'h47, 8'(i)}, {16'h0, ctrl_word});
		end
	endtask

	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		own_addr = 7'h7e;
		baud_div = BD;
		status_word = ST;
		out_freq = FQ;
		ans_cfg = '0;
		ans_dly = 1;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		s_reset;
		s_short;
		s_bcast;
		s_drop;
		s_param;
		check("line clash", 0, u_bus_master_model.oe_clash);
		check("bad reply chars", 0, u_bus_master_model.rx_bad);
		tally_and_finish;
	end
endmodule
